// File: common/side_channel_consts.vh
`ifndef SIDE_CHANNEL_CONSTS_VH
`define SIDE_CHANNEL_CONSTS_VH
// register offsets
`define OFS_PIN9_CFG        8'h1A
`define OFS_PIN0_CFG        8'h1D
`define OFS_PIN12_CFG       8'h1E
`define OFS_PIN3_CFG        8'h1F
`define OFS_LOCAL56_CFG     8'h20
`define OFS_LOCAL78_CFG     8'h21
`define OFS_BC_RATE         8'h23
`define OFS_PORT_SEL        8'h34
`define OFS_MODE_CTL        8'h43
`define OFS_STATUS_LOW      8'h6E
`define OFS_STATUS_HIGH     8'h6F
// field positions
`define BIT_RATE_SEL        6
`define BIT_HIGH_SPEED      4
`define BIT_FIRST_PORT      0
`define BIT_SECOND_PORT     1
// reset values
`define RST_CFG             8'h00
`define RST_BC_RATE         8'h00
`define RST_PORT_SEL        8'h01
`define RST_MODE_CTL        8'h00
// pin field codes
`define CODE_OUT_LOW        4'h1
`define CODE_INPUT          4'h3
`define CODE_FWD_OUT        4'h5
`define CODE_OUT_HIGH       4'h9
// side channel modes
`define MODE_NORMAL         3'h0
`define MODE_FAST_ONE       3'h1
`define MODE_FAST_TWO       3'h2
`define MODE_FAST_FOUR      3'h3
`define MODE_SPI_FWD        3'h6
`define MODE_SPI_REV        3'h7
// samples per frame in the fast modes
`define SAMP_FAST_FOUR      5'h06
`define SAMP_FAST_TWO       5'h0A
`define SAMP_FAST_ONE       5'h0F
// back channel bit dividers and frame length
`define DIV_LOW_RATE        3'h4
`define DIV_MID_RATE        3'h2
`define DIV_HIGH_RATE       3'h1
`define FRAME_LAST_BIT      5'h1F
`endif

// File: design/gpio_and_spi_side_channel.v
`timescale 1ns/1ns
`default_nettype none
`include "side_channel_consts.vh"
module gpio_and_spi_side_channel (
  input  wire        clk,          // 10 MHz system clock
  input  wire        reset,        // synchronous, active high
  input  wire        reg_wr,       // register write strobe
  input  wire        reg_rd,       // register read strobe
  input  wire [7:0]  reg_addr,     // register offset
  input  wire [7:0]  reg_wdata,    // register write data
  output reg  [7:0]  reg_rdata,    // register read data
  input  wire        two_lane,     // link runs in two-lane mode
  input  wire        link_lock,    // receiver lock status
  input  wire        mode_strap_pin, // high-speed strap pin
  input  wire [7:0]  mgmt_byte,    // management traffic for frame
  input  wire [3:0]  fwd_gpio,     // forward data, primary pins
  input  wire [3:0]  fwd_d_gpio,   // forward data, secondary pins
  input  wire [3:0]  gpio_in,      // primary pin level
  output wire [3:0]  gpio_out,     // primary pin drive value
  output wire [3:0]  gpio_oe,      // primary pin drive enable
  input  wire [3:0]  d_gpio_in,    // secondary pin level
  output wire [3:0]  d_gpio_out,   // secondary pin drive value
  output wire [3:0]  d_gpio_oe,    // secondary pin drive enable
  input  wire [4:0]  loc_pin_in,   // local pins 5..9 level
  output wire [4:0]  loc_pin_out,  // local pins 5..9 drive value
  output wire [4:0]  loc_pin_oe,   // local pins 5..9 drive enable
  output wire [3:0]  audio_pin_taken, // pins 5..8 held from audio
  output reg         bc_bit_en,    // back channel bit tick
  output reg         bc_frame,     // frame boundary pulse
  output reg  [31:0] bc_word,      // completed frame payload
  input  wire        pclk,         // recovered pixel clock
  input  wire        spi_clk_bit,  // forward frame SPI clock bit
  input  wire        spi_data_bit, // forward frame SPI data bit
  input  wire        spi_cs_bit,   // forward frame SPI select bit
  input  wire        spi_poci_in,  // returned peripheral data
  output reg         tunnelled_spi_clock, // regenerated SPI clock
  output reg         spi_pico,     // regenerated controller data
  output reg         spi_cs_n,     // regenerated select, low active
  output reg         spi_poci_hold // returned data to the link
);

  // pin field decode helpers
  function drive_en;
    input [3:0] code;
    begin
      drive_en = (code == `CODE_OUT_LOW) || (code == `CODE_OUT_HIGH) ||
                 (code == `CODE_FWD_OUT);
    end
  endfunction

  function drive_val;
    input [3:0] code;
    input       fwd;
    begin
      if (code == `CODE_FWD_OUT)
        drive_val = fwd;
      else
        drive_val = (code == `CODE_OUT_HIGH);
    end
  endfunction

  // registers
  reg  [7:0]  p0_cfg0_r;
  reg  [7:0]  p0_cfg12_r;
  reg  [7:0]  p0_cfg3_r;
  reg  [7:0]  p1_cfg0_r;
  reg  [7:0]  p1_cfg12_r;
  reg  [7:0]  p1_cfg3_r;
  reg  [7:0]  pin9_cfg_r;
  reg  [7:0]  loc56_cfg_r;
  reg  [7:0]  loc78_cfg_r;
  reg  [7:0]  bc_rate_r;
  reg  [7:0]  port_sel_r;
  reg  [7:0]  mode_ctl_r;
  reg         strap_r;
  reg         strap_seen_r;

  wire first_sel  = port_sel_r[`BIT_FIRST_PORT];
  wire second_sel = port_sel_r[`BIT_SECOND_PORT];

  // host bus writes only; shared pin fields go to every selected port
  always @(posedge clk) begin
    if (reset) begin
      p0_cfg0_r   <= `RST_CFG;
      p0_cfg12_r  <= `RST_CFG;
      p0_cfg3_r   <= `RST_CFG;
      p1_cfg0_r   <= `RST_CFG;
      p1_cfg12_r  <= `RST_CFG;
      p1_cfg3_r   <= `RST_CFG;
      pin9_cfg_r  <= `RST_CFG;
      loc56_cfg_r <= `RST_CFG;
      loc78_cfg_r <= `RST_CFG;
      bc_rate_r   <= `RST_BC_RATE;
      port_sel_r  <= `RST_PORT_SEL;
      mode_ctl_r  <= `RST_MODE_CTL;
    end else if (reg_wr) begin
      case (reg_addr)
        `OFS_PIN0_CFG: begin
          if (first_sel)
            p0_cfg0_r <= reg_wdata;
          if (second_sel)
            p1_cfg0_r <= reg_wdata;
        end
        `OFS_PIN12_CFG: begin
          if (first_sel)
            p0_cfg12_r <= reg_wdata;
          if (second_sel)
            p1_cfg12_r <= reg_wdata;
        end
        `OFS_PIN3_CFG: begin
          if (first_sel)
            p0_cfg3_r <= reg_wdata;
          if (second_sel)
            p1_cfg3_r <= reg_wdata;
        end
        `OFS_PIN9_CFG:    pin9_cfg_r  <= reg_wdata;
        `OFS_LOCAL56_CFG: loc56_cfg_r <= reg_wdata;
        `OFS_LOCAL78_CFG: loc78_cfg_r <= reg_wdata;
        `OFS_BC_RATE:     bc_rate_r   <= reg_wdata;
        `OFS_PORT_SEL:    port_sel_r  <= reg_wdata;
        `OFS_MODE_CTL:    mode_ctl_r  <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // strap is caught once, on the first edge after reset release
  always @(posedge clk) begin
    if (reset) begin
      strap_r      <= 1'b0;
      strap_seen_r <= 1'b0;
    end else if (!strap_seen_r) begin
      strap_r      <= mode_strap_pin;
      strap_seen_r <= 1'b1;
    end
  end

  // two-stage synchronisers for every pin level, the pixel clock and the forward SPI bits
  reg [17:0] sync1_r;
  reg [17:0] sync2_r;
  always @(posedge clk) begin
    if (reset) begin
      sync1_r <= 18'h00000;
      sync2_r <= 18'h00000;
    end else begin
      sync1_r <= {spi_poci_in, spi_cs_bit, spi_data_bit, spi_clk_bit,
                  loc_pin_in, pclk, d_gpio_in, gpio_in};
      sync2_r <= sync1_r;
    end
  end
  wire [3:0] gp_s       = sync2_r[3:0];
  wire [3:0] dgp_s      = sync2_r[7:4];
  wire       pclk_s     = sync2_r[8];
  wire [4:0] loc_s      = sync2_r[13:9];
  wire       spi_clk_s  = sync2_r[14];
  wire       spi_data_s = sync2_r[15];
  wire       spi_cs_s   = sync2_r[16];
  wire       poci_s     = sync2_r[17];

  // pin nibbles per port
  wire [15:0] p0_codes = {p0_cfg3_r[3:0], p0_cfg12_r[7:4],
                          p0_cfg12_r[3:0], p0_cfg0_r[3:0]};
  wire [15:0] p1_codes = {p1_cfg3_r[3:0], p1_cfg12_r[7:4],
                          p1_cfg12_r[3:0], p1_cfg0_r[3:0]};
  wire [19:0] loc_codes = {pin9_cfg_r[3:0], loc78_cfg_r[7:4],
                           loc78_cfg_r[3:0], loc56_cfg_r[7:4],
                           loc56_cfg_r[3:0]};
  wire [3:0]  gp_is_in;
  wire [3:0]  dgp_is_in;

  // link pin drivers; the secondary set stays idle outside two-lane
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_link
      assign gpio_oe[i]    = drive_en(p0_codes[4*i+3:4*i]);
      assign gpio_out[i]   = drive_val(p0_codes[4*i+3:4*i],
                                       fwd_gpio[i]);
      assign d_gpio_oe[i]  = two_lane &&
                             drive_en(p1_codes[4*i+3:4*i]);
      assign d_gpio_out[i] = two_lane &&
                             drive_val(p1_codes[4*i+3:4*i],
                                       fwd_d_gpio[i]);
      assign gp_is_in[i]   = (p0_codes[4*i+3:4*i] == `CODE_INPUT);
      assign dgp_is_in[i]  = two_lane &&
                             (p1_codes[4*i+3:4*i] == `CODE_INPUT);
    end
    // local pins; forward code is not honoured, nothing crosses the link
    for (i = 0; i < 5; i = i + 1) begin : g_local
      assign loc_pin_oe[i]  = (loc_codes[4*i+3:4*i] == `CODE_OUT_LOW) ||
                              (loc_codes[4*i+3:4*i] ==
                               `CODE_OUT_HIGH);
      assign loc_pin_out[i] = (loc_codes[4*i+3:4*i] ==
                               `CODE_OUT_HIGH);
    end
    // register-only pins 5..8 claim the shared audio input when set as input or output
    for (i = 0; i < 4; i = i + 1) begin : g_audio
      assign audio_pin_taken[i] =
        loc_pin_oe[i] ||
        (loc_codes[4*i+3:4*i] == `CODE_INPUT);
    end
  endgenerate

  // status bytes from synchronised levels
  wire [3:0] link_lvl = second_sel ? dgp_s : gp_s;
  wire [7:0] status_low  = {loc_s[2:0], 1'b0, link_lvl};
  wire [7:0] status_high = {6'h00, loc_s[4:3]};

  // register reads; with both selects set port one is returned
  always @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `OFS_PIN0_CFG:    reg_rdata <= second_sel ? p1_cfg0_r
                                                  : p0_cfg0_r;
        `OFS_PIN12_CFG:   reg_rdata <= second_sel ? p1_cfg12_r
                                                  : p0_cfg12_r;
        `OFS_PIN3_CFG:    reg_rdata <= second_sel ? p1_cfg3_r
                                                  : p0_cfg3_r;
        `OFS_PIN9_CFG:    reg_rdata <= pin9_cfg_r;
        `OFS_LOCAL56_CFG: reg_rdata <= loc56_cfg_r;
        `OFS_LOCAL78_CFG: reg_rdata <= loc78_cfg_r;
        `OFS_BC_RATE:     reg_rdata <= bc_rate_r;
        `OFS_PORT_SEL:    reg_rdata <= port_sel_r;
        `OFS_MODE_CTL:    reg_rdata <= mode_ctl_r;
        `OFS_STATUS_LOW:  reg_rdata <= status_low;
        `OFS_STATUS_HIGH: reg_rdata <= status_high;
        default:          reg_rdata <= 8'h00;
      endcase
    end
  end

  // back channel bit rate divider
  wire       high_speed = bc_rate_r[`BIT_HIGH_SPEED] | strap_r;
  wire [2:0] div_sel    = high_speed ? `DIV_HIGH_RATE :
                          (bc_rate_r[`BIT_RATE_SEL] ? `DIV_MID_RATE
                                                    : `DIV_LOW_RATE);
  reg  [2:0] div_cnt_r;
  always @(posedge clk) begin
    if (reset) begin
      div_cnt_r <= 3'h0;
      bc_bit_en <= 1'b0;
    end else if (div_cnt_r >= div_sel - 3'h1) begin
      div_cnt_r <= 3'h0;
      bc_bit_en <= 1'b1;
    end else begin
      div_cnt_r <= div_cnt_r + 3'h1;
      bc_bit_en <= 1'b0;
    end
  end

  // frame sequencer; mode is taken over only at a frame boundary
  reg  [4:0]  bit_cnt_r;
  reg  [2:0]  mode_act_r;
  reg  [23:0] samp_r;
  reg  [4:0]  nsamp;
  wire        frame_end = bc_bit_en && (bit_cnt_r == `FRAME_LAST_BIT);

  always @* begin
    case (mode_act_r)
      `MODE_FAST_FOUR: nsamp = `SAMP_FAST_FOUR;
      `MODE_FAST_TWO:  nsamp = `SAMP_FAST_TWO;
      `MODE_FAST_ONE:  nsamp = `SAMP_FAST_ONE;
      default:         nsamp = 5'h00;
    endcase
  end

  wire [3:0] dgp_masked = dgp_s & dgp_is_in;
  wire [3:0] gp_masked  = gp_s & gp_is_in;

  // sampling of secondary pins within the frame
  always @(posedge clk) begin
    if (reset) begin
      bit_cnt_r  <= 5'h00;
      mode_act_r <= `MODE_NORMAL;
      samp_r     <= 24'h000000;
    end else if (bc_bit_en) begin
      bit_cnt_r <= bit_cnt_r + 5'h01;
      if (frame_end) begin
        mode_act_r <= mode_ctl_r[2:0];
        samp_r     <= 24'h000000;
      end else if (bit_cnt_r < nsamp) begin
        case (mode_act_r)
          `MODE_FAST_FOUR: samp_r <= {samp_r[19:0], dgp_masked};
          `MODE_FAST_TWO:  samp_r <= {samp_r[21:0],
                                      dgp_masked[1:0]};
          default:         samp_r <= {samp_r[22:0], dgp_masked[0]};
        endcase
      end
    end
  end

  // frame assembly
  wire [15:0] norm_body = {mgmt_byte, gp_masked, dgp_masked};
  wire [3:0]  crc = norm_body[15:12] ^ norm_body[11:8] ^
                    norm_body[7:4] ^ norm_body[3:0] ^
                    {3'h0, link_lock};
  reg  [28:0] payload;
  always @* begin
    case (mode_act_r)
      `MODE_NORMAL:    payload = {8'h00, link_lock, crc,
                                  norm_body};
      `MODE_FAST_ONE,
      `MODE_FAST_TWO,
      `MODE_FAST_FOUR: payload = {5'h00, samp_r};
      `MODE_SPI_FWD:   payload = {28'h0000000,
                                  spi_poci_hold};
      default:         payload = 29'h00000000;
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      bc_frame <= 1'b0;
      bc_word  <= 32'h00000000;
    end else begin
      bc_frame <= frame_end;
      if (frame_end)
        bc_word <= {mode_act_r, payload};
    end
  end

  // forward SPI regeneration on each rising recovered pixel clock edge
  reg  pclk_d_r;
  reg  spi_clk_d_r;
  wire pclk_rise = pclk_s && !pclk_d_r;
  wire spi_on    = two_lane && (mode_act_r == `MODE_SPI_FWD);
  always @(posedge clk) begin
    if (reset) begin
      pclk_d_r            <= 1'b0;
      spi_clk_d_r         <= 1'b0;
      tunnelled_spi_clock <= 1'b0;
      spi_pico            <= 1'b0;
      spi_cs_n            <= 1'b1;
      spi_poci_hold       <= 1'b0;
    end else begin
      pclk_d_r <= pclk_s;
      if (!spi_on) begin
        spi_clk_d_r         <= 1'b0;
        tunnelled_spi_clock <= 1'b0;
        spi_cs_n            <= 1'b1;
      end else if (pclk_rise) begin
        spi_pico            <= spi_data_s;
        spi_cs_n            <= spi_cs_s;
        spi_clk_d_r         <= spi_clk_s;
        tunnelled_spi_clock <= spi_clk_d_r;
        if (!tunnelled_spi_clock)
          spi_poci_hold <= poci_s;
      end
    end
  end

endmodule
`default_nettype wire

// File: verification/serializer_model.sv
`timescale 1ns/1ns
`default_nettype none
module serializer_model (
  output logic       pclk,         // recovered pixel clock
  output logic       spi_clk_bit,  // sampled controller clock
  output logic       spi_data_bit, // sampled controller data
  output logic       spi_cs_bit,   // sampled select, low active
  output logic [3:0] fwd_gpio,     // forward data, primary pins
  output logic [3:0] fwd_d_gpio    // forward data, secondary pins
);
  logic [7:0] pat;

  // serializer pins set as inputs send fixed levels forward
  assign fwd_gpio   = 4'hA;
  assign fwd_d_gpio = 4'h5;

  // free running pixel clock, phase unrelated to the system clock
  initial begin
    pclk = 1'b0;
    #37;
    forever #400 pclk = ~pclk;
  end

  // spi bits move on falling pixel edges; slow enough for round trips
  initial begin
    spi_clk_bit  = 1'b0;
    spi_data_bit = 1'b0;
    spi_cs_bit   = 1'b1;
    pat          = 8'hB4;
  end
  always @(negedge pclk) begin
    spi_clk_bit  <= ~spi_clk_bit;
    spi_data_bit <= pat[7];
    pat          <= {pat[6:0], pat[7]};
    spi_cs_bit   <= 1'b0;
  end
endmodule
`default_nettype wire

// File: verification/side_channel_chk.sv
`timescale 1ns/1ns
`default_nettype none
module side_channel_chk (
  input wire        clk,                 // system clock
  input wire        reset,               // synchronous reset
  input wire        reg_rd,              // register read strobe
  input wire [7:0]  reg_rdata,           // register read data
  input wire        two_lane,            // two-lane mode
  input wire [3:0]  d_gpio_oe,           // secondary drive enable
  input wire [4:0]  loc_pin_oe,          // local drive enable
  input wire [3:0]  audio_pin_taken,     // pins held from audio
  input wire        bc_bit_en,           // bit tick
  input wire        bc_frame,            // frame pulse
  input wire [31:0] bc_word,             // frame payload
  input wire        tunnelled_spi_clock, // regenerated clock
  input wire        spi_cs_n,            // regenerated select
  input wire        spi_poci_hold        // returned data
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // frame timing and payload hold
  a_frame_gap: assert property (
    bc_frame |=> !bc_frame [*8]) else $error("frame pulse too soon");
  a_frame_tick: assert property (
    bc_frame |-> $past(bc_bit_en)) else $error("frame not on a tick");
  a_word_hold: assert property (
    !bc_frame && !$past(reset) |-> $stable(bc_word))
    else $error("frame word moved between frames");
  // pin ownership
  a_local_owned: assert property (
    (loc_pin_oe[3:0] & ~audio_pin_taken) == 4'h0)
    else $error("local pin driven while audio owns it");
  a_lane_gate: assert property (
    !two_lane |-> d_gpio_oe == 4'h0) else $error("secondary pin driven");
  // spi regeneration, read data hold and coverage
  a_spi_lane: assert property (
    !two_lane && !$past(two_lane) && !$past(two_lane, 2)
    |-> spi_cs_n && !tunnelled_spi_clock) else $error("spi active");
  a_poci_hold: assert property (
    tunnelled_spi_clock |=> $stable(spi_poci_hold))
    else $error("returned data moved while clock high");
  a_rdata_hold: assert property (
    !$past(reg_rd) && !$past(reset) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  c_frame: cover property (bc_frame);
  c_spi_clk: cover property ($rose(tunnelled_spi_clock));
  c_local: cover property (loc_pin_oe[0]);
endmodule
`default_nettype wire

// File: verification/gpio_and_spi_side_channel_tb.sv
`timescale 1ns/1ns
`default_nettype none
module gpio_and_spi_side_channel_tb;
  logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, two_lane = 0;
  logic link_lock = 0, mode_strap_pin = 0, spi_poci_in = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, mgmt_byte = 8'hC3, reg_rdata;
  logic [3:0] gpio_in = 0, d_gpio_in = 0, gpio_out, gpio_oe, d_gpio_out;
  logic [3:0] d_gpio_oe, audio_pin_taken, fwd_gpio, fwd_d_gpio;
  logic [4:0] loc_pin_in = 0, loc_pin_out, loc_pin_oe;
  logic [31:0] bc_word;
  logic bc_bit_en, bc_frame, pclk, spi_clk_bit, spi_data_bit, spi_cs_bit;
  logic tunnelled_spi_clock, spi_pico, spi_cs_n, spi_poci_hold, d, c, s, pc;
  logic pp, ph, v;
  logic [7:0] rates [4] = '{8'h00, 8'h40, 8'h10, 8'h50};
  logic [3:0] codes [3] = '{4'h1, 4'h9, 4'h3};
  logic [2:0] modes [4] = '{3'h3, 3'h2, 3'h1, 3'h7};
  logic [28:0] fast [4] = '{29'h777777, 29'h0FFFFF, 29'h007FFF, 29'h0};
  integer miscompares = 0, n_compared = 0;

  gpio_and_spi_side_channel dut (.clk(clk), .reset(reset),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .two_lane(two_lane),
    .link_lock(link_lock), .mode_strap_pin(mode_strap_pin),
    .mgmt_byte(mgmt_byte), .fwd_gpio(fwd_gpio), .fwd_d_gpio(fwd_d_gpio),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .d_gpio_in(d_gpio_in), .d_gpio_out(d_gpio_out), .d_gpio_oe(d_gpio_oe),
    .loc_pin_in(loc_pin_in), .loc_pin_out(loc_pin_out),
    .loc_pin_oe(loc_pin_oe), .audio_pin_taken(audio_pin_taken),
    .bc_bit_en(bc_bit_en), .bc_frame(bc_frame), .bc_word(bc_word),
    .pclk(pclk), .spi_clk_bit(spi_clk_bit), .spi_data_bit(spi_data_bit),
    .spi_cs_bit(spi_cs_bit), .spi_poci_in(spi_poci_in),
    .tunnelled_spi_clock(tunnelled_spi_clock), .spi_pico(spi_pico),
    .spi_cs_n(spi_cs_n), .spi_poci_hold(spi_poci_hold));
  serializer_model far (.pclk(pclk), .spi_clk_bit(spi_clk_bit),
    .spi_data_bit(spi_data_bit), .spi_cs_bit(spi_cs_bit),
    .fwd_gpio(fwd_gpio), .fwd_d_gpio(fwd_d_gpio));

  // system clock
  always #50 clk = ~clk;

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1;
    @(negedge clk);
    reg_wr = 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1;
    @(negedge clk);
    reg_rd = 0;
    @(negedge clk);
    chk(nm, e, reg_rdata);
  endtask
  task wait_frame;
    integer n;
    n = 0;
    @(negedge clk);
    while (bc_frame !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (n >= 300) chk("frame_wait", 0, n);
  endtask
  task gap(input logic [31:0] e);
    integer n;
    n = 0;
    while (bc_bit_en !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (bc_bit_en !== 1'b1 && n < 20);
    chk("tick_gap", e, n);
  endtask
  task pulse_reset;
    reset = 1;
    repeat (3) @(negedge clk);
    reset = 0;
  endtask

  // reset values, unmapped and read-only places
  task t_regs;
    rd(8'h34, 8'h01, "port_sel");
    rd(8'h43, 8'h00, "mode_ctl");
    rd(8'h1D, 8'h00, "pin0_cfg");
    rd(8'h50, 8'h00, "unmapped");
    wr(8'h6E, 8'hFF);
    rd(8'h6E, 8'h00, "status_ro");
  endtask
  // bit tick dividers from register and strap
  task t_rate;
    for (int i = 0; i < 4; i++) begin
      wr(8'h23, rates[i]);
      repeat (10) @(negedge clk);
      gap(rates[i][4] ? 1 : (rates[i][6] ? 2 : 4));
    end
    mode_strap_pin = 1;
    pulse_reset;
    gap(1);
    mode_strap_pin = 0;
    pulse_reset;
    gap(4);
  endtask
  // link pin directions and port steering
  task t_link;
    two_lane = 1;
    wr(8'h34, 8'h03);
    wr(8'h1D, 8'h05);
    chk("gpio_oe0", 1, gpio_oe[0]);
    chk("gpio_out0", fwd_gpio[0], gpio_out[0]);
    chk("d_gpio_out0", fwd_d_gpio[0], d_gpio_out[0] & d_gpio_oe[0]);
    wr(8'h34, 8'h01);
    wr(8'h1D, 8'h09);
    chk("gpio_local_hi", 1, gpio_out[0] & gpio_oe[0]);
    wr(8'h34, 8'h02);
    rd(8'h1D, 8'h05, "port1_copy");
    two_lane = 0;
    @(negedge clk);
    chk("d_gpio_oe_1lane", 0, d_gpio_oe);
    two_lane = 1;
    wr(8'h34, 8'h01);
    wr(8'h1D, 8'h03);
    chk("gpio_oe_in", 0, gpio_oe[0]);
  endtask
  // local pin codes and status bits
  task t_local;
    gpio_in = 4'h1;
    loc_pin_in = 5'h11;
    for (int i = 0; i < 3; i++) begin
      wr(8'h20, {4'h0, codes[i]});
      chk("loc_oe5", codes[i] != 4'h3, loc_pin_oe[0]);
      if (codes[i] != 4'h3)
        chk("loc_out5", codes[i] == 4'h9, loc_pin_out[0]);
      chk("audio5", 1, audio_pin_taken[0]);
    end
    rd(8'h6E, 8'h21, "status_low");
    wr(8'h1A, 8'h03);
    rd(8'h6F, 8'h02, "status_high");
    wr(8'h20, 8'h05);
    chk("audio5_fwd", 0, audio_pin_taken[0]);
    chk("loc_oe5_fwd", 0, loc_pin_oe[0]);
    wr(8'h20, 8'h00);
    chk("audio5_free", 0, audio_pin_taken[0]);
  endtask
  // frame payloads, fast modes and boundary switching
  task t_frame;
    link_lock = 1;
    gpio_in = 4'h9;
    d_gpio_in = 4'h6;
    wr(8'h34, 8'h03);
    wr(8'h1E, 8'h33);
    wr(8'h1F, 8'h03);
    wr(8'h1D, 8'h03);
    wr(8'h23, 8'h10);
    wait_frame;
    wait_frame;
    chk("normal_mode", 0, bc_word[31:29]);
    chk("normal_low", {mgmt_byte, 8'h96}, bc_word[15:0]);
    chk("normal_lock", 1, bc_word[20]);
    d_gpio_in = 4'h7;
    for (int i = 0; i < 4; i++) begin
      wait_frame;
      repeat (3) @(negedge clk);
      wr(8'h43, {5'h00, modes[i]});
      wait_frame;
      chk("old_mode", i == 0 ? 0 : modes[i-1], bc_word[31:29]);
      wait_frame;
      chk("new_mode", modes[i], bc_word[31:29]);
      chk("fast_payload", fast[i], bc_word[28:0]);
    end
  endtask
  // forward spi regeneration on the pixel clock
  task t_spi;
    wr(8'h43, 8'h06);
    wait_frame;
    wait_frame;
    chk("spi_mode", 6, bc_word[31:29]);
    v = 0;
    // two pixel edges prime the clock delay line
    @(posedge pclk);
    pp = spi_clk_bit;
    @(posedge pclk);
    pc = spi_clk_bit;
    repeat (6) begin
      @(posedge pclk);
      d = spi_data_bit;
      c = spi_clk_bit;
      s = spi_cs_bit;
      if (!pp) ph = spi_poci_in;
      v = v | !pp;
      repeat (6) @(negedge clk);
      chk("spi_pico", d, spi_pico);
      chk("spi_cs_n", s, spi_cs_n);
      chk("spi_clk_lag", pc, tunnelled_spi_clock);
      if (v) chk("spi_poci_hold", ph, spi_poci_hold);
      pp = pc;
      pc = c;
      spi_poci_in = ~spi_poci_in;
    end
    rd(8'h43, 8'h06, "spi_no_reg");
  endtask

  task results;
    $display("compared %0d wrong %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (6) @(negedge clk);
    reset = 0;
    t_regs;
    t_rate;
    t_link;
    t_local;
    t_frame;
    t_spi;
    results;
  end
  // watchdog
  initial begin
    #1000000;
    $display("wrong value watchdog expected done seen timeout");
    miscompares++;
    results;
  end
endmodule
bind gpio_and_spi_side_channel side_channel_chk chk_i (.clk(clk),
  .reset(reset), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .two_lane(two_lane), .d_gpio_oe(d_gpio_oe), .loc_pin_oe(loc_pin_oe),
  .audio_pin_taken(audio_pin_taken), .bc_bit_en(bc_bit_en),
  .bc_frame(bc_frame), .bc_word(bc_word),
  .tunnelled_spi_clock(tunnelled_spi_clock), .spi_cs_n(spi_cs_n),
  .spi_poci_hold(spi_poci_hold));
`default_nettype wire
